// [test/ccmc_pin_model.sv]
// External event source and load on the two unit pins.
`timescale 1ns/10ps
module ccmc_pin_model (
  // Source levels chosen by the bench
  input wire logic drv_a_i,
  input wire logic drv_pin_i,
  // Device side
  input wire logic [3:0] enh_out_i,
  input wire logic [3:0] enh_oe_i,
  input wire logic pin_out_i,
  input wire logic pin_oe_i,
  // Resolved pad levels
  output logic pad_a_o,
  output logic pad_pin_o
);
  // A driven pin reads back its own level, so a level change there still counts as an event.
  assign pad_a_o = enh_oe_i[0] ? enh_out_i[0] : drv_a_i;
  assign pad_pin_o = pin_oe_i ? pin_out_i : drv_pin_i;
endmodule : ccmc_pin_model

// [test/ccmc_top_sva.sv]
// Concurrent checks on the ports of the capture/compare mode control block.
`timescale 1ns/10ps
module ccmc_chk
  import ccmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Timer, converter and pins
  input wire logic [15:0] timer_one_count_i,
  input wire logic timer_reset_o,
  input wire logic adc_enable_i,
  input wire logic adc_start_o,
  input wire logic [3:0] enh_oe_o,
  input wire logic unit_pin_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (s_rd ##0 (wb_adr_i > ADR_IRQ_EN) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_sec_ctrl_bits: assert property (s_rd ##0 (wb_adr_i == ADR_SEC_CTRL) |-> wb_dat_o[31:6] == 26'h0)
    else $error("second control upper bits set");
  a_stat_width: assert property (s_rd ##0 (wb_adr_i == ADR_IRQ_STAT) |-> wb_dat_o[31:2] == 30'h0)
    else $error("status upper bits set");
  a_adc_gated: assert property (adc_start_o == (timer_reset_o && adc_enable_i))
    else $error("conversion start not gated by enable");
  // Without a bus write the compare pair is fixed, so the trigger may only follow the timer.
  a_trig_steady: assert property (!$past(wb_ack_o) && $stable(timer_one_count_i) |-> $stable(timer_reset_o))
    else $error("trigger moved with timer steady");
  a_reset_idle: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && enh_oe_o == 4'h0 && !unit_pin_oe_o)
    else $error("outputs active after reset");
  a_flag_sticky: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt dropped without a bus write");
endmodule : ccmc_chk

bind ccmc_top ccmc_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .timer_one_count_i, .timer_reset_o, .adc_enable_i, .adc_start_o,
  .enh_oe_o, .unit_pin_oe_o, .irq_o);

// [test/ccmc_top_tb.sv]
// Self-checking bench for the capture/compare mode control block.
`timescale 1ns/10ps
module ccmc_top_tb;
  import ccmc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ccmc_row_t;
  logic clk_i, rst_i, cyc, stb, we, adc_en, pad_a, pad_pin, ack, trst, adc_st, pin_o, pin_oe, irq;
  logic [1:0] drv;
  logic [3:0] sel = 4'hf;
  logic [3:0] eout, eoe;
  logic [7:0] adr, ca, va;
  logic [15:0] tmr;
  logic [31:0] wdat, rdat, dat_o;
  ccmc_pwm_base_t pb;
  int miscompares = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int dv;
  ccmc_row_t rows [14] = '{'{0, ADR_ENH_CTRL, 0, 0}, '{0, ADR_SEC_CTRL, 0, 0},
    '{0, ADR_ENH_VAL, 0, 0}, '{0, ADR_SEC_VAL, 0, 0}, '{0, ADR_IRQ_STAT, 0, 0},
    '{0, ADR_IRQ_EN, 0, 0}, '{1, ADR_ENH_CTRL, 'hf5, 'hf5}, '{1, ADR_SEC_CTRL, 'hff, 'h3f},
    '{1, ADR_SEC_VAL, 'h1234, 'h34},
    '{1, ADR_ENH_VAL, 'habcd, 'habcd}, '{1, ADR_IRQ_EN, 3, 3}, '{1, 8'h28, '1, 0},
    '{1, ADR_ENH_CTRL, 0, 0}, '{1, ADR_SEC_CTRL, 0, 0}};
  logic [3:0] cm [5] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_SWI, MODE_SPECIAL};
  logic [1:0] ce [5] = '{2'b11, 2'b01, 2'b11, 2'b00, 2'b00};

  ccmc_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_one_count_i(tmr), .timer_reset_o(trst), .adc_enable_i(adc_en),
    .adc_start_o(adc_st), .pwm_base_i(pb), .output_a_i(pad_a), .enh_out_o(eout),
    .enh_oe_o(eoe), .unit_pin_i(pad_pin), .unit_pin_o(pin_o), .unit_pin_oe_o(pin_oe),
    .irq_o(irq));
  ccmc_pin_model u_pin (.drv_a_i(drv[0]), .drv_pin_i(drv[1]), .enh_out_i(eout),
    .enh_oe_i(eoe), .pin_out_i(pin_o), .pin_oe_i(pin_oe), .pad_a_o(pad_a),
    .pad_pin_o(pad_pin));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // The whole sequence needs well under 8000 cycles.
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rd_chk
  task automatic pulse(input int u);
    drv[u] <= 1'b1;
    repeat (6) @(posedge clk_i);
    drv[u] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulse
  task automatic period();
    pb <= '{10'h0, 1'b1};
    @(posedge clk_i);
    pb.period <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : period
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_i, cyc, stb, we, adc_en, drv, adr, wdat, tmr} = '0;
    rst_i = 1'b1;
    pb = '{10'h0, 1'b0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
      rd_chk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
    end
    for (int u = 0; u < 2; u++) begin
      for (int m = 4; m < 8; m++) begin
        dv = (m == 6) ? 4 : (m == 7) ? 16 : 1;
        ca = u ? ADR_SEC_CTRL : ADR_ENH_CTRL;
        va = u ? ADR_SEC_VAL : ADR_ENH_VAL;
        wb(1'b1, ca, 0);
        wb(1'b1, ca, m);
        wb(1'b1, ADR_IRQ_CLR, 3);
        repeat (dv - 1) pulse(u);
        rd_chk("early flag", ADR_IRQ_STAT, 0);
        tmr <= 16'h1000 + 16'(m);
        pulse(u);
        rd_chk("flag", ADR_IRQ_STAT, 1 << u);
        chk("irq", 1, irq);
        rd_chk("value", va, 16'h1000 + m);
        tmr <= 16'h2000 + 16'(m);
        repeat (dv) pulse(u);
        rd_chk("overwrite", va, 16'h2000 + m);
        rd_chk("flag kept", ADR_IRQ_STAT, 1 << u);
      end
    end
    wb(1'b1, ADR_IRQ_EN, 0);
    chk("masked irq", 0, irq);
    wb(1'b1, ADR_IRQ_CLR, 3);
    rd_chk("cleared", ADR_IRQ_STAT, 0);
    wb(1'b1, ADR_IRQ_EN, 3);
    wb(1'b1, ADR_SEC_CTRL, 0);
    tmr <= 16'h0;
    adc_en <= 1'b1;
    wb(1'b1, ADR_ENH_VAL, 32'h40);
    wb(1'b1, ADR_SEC_VAL, 32'h40);
    foreach (cm[i]) begin
      wb(1'b1, ADR_ENH_CTRL, cm[i]);
      wb(1'b1, ADR_SEC_CTRL, cm[i]);
      wb(1'b1, ADR_IRQ_CLR, 3);
      tmr <= 16'h0040;
      @(posedge clk_i);
      if (cm[i] == MODE_SPECIAL) chk("trigger", 1, trst);
      if (cm[i] == MODE_SPECIAL) chk("adc start", 1, adc_st);
      repeat (3) @(posedge clk_i);
      tmr <= 16'h0;
      @(posedge clk_i);
      chk("pin drive", ce[i][0], eoe[0]);
      if (ce[i][0]) chk("pin level", ce[i][1], eout[0]);
      chk("pin2 drive", ce[i][0] && (cm[i] != MODE_TOGGLE), pin_oe);
      if (pin_oe === 1'b1) chk("pin2 level", ce[i][1], pin_o);
      rd_chk("match flag", ADR_IRQ_STAT, (cm[i] == MODE_TOGGLE) ? 1 : 3);
    end
    wb(1'b1, ADR_ENH_CTRL, 0);
    wb(1'b1, ADR_ENH_CTRL, MODE_SET);
    repeat (2) @(posedge clk_i);
    chk("latch drive", 1, eoe[0]);
    chk("latch cleared", 0, eout[0]);
    wb(1'b1, ADR_ENH_VAL, 32'h1);
    wb(1'b1, ADR_ENH_CTRL, 32'h0c);
    period();
    chk("pwm high", 1, eout[0]);
    chk("single oe", 4'h1, eoe);
    pb.base <= 10'h4;
    repeat (3) @(posedge clk_i);
    chk("pwm low", 0, eout[0]);
    wb(1'b1, ADR_ENH_CTRL, 32'h8c);
    period();
    chk("half oe", 4'h3, eoe);
    chk("half pair", 4'h1, eout);
    wb(1'b1, ADR_ENH_CTRL, 32'h0e);
    period();
    chk("active low", 0, eout[0]);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("oe after reset", 0, eoe);
    rd_chk("ctrl after reset", ADR_ENH_CTRL, 0);
    complete_run();
  end
endmodule : ccmc_top_tb

// [verilog/ccmc_pkg.sv]
// Constants and types shared by the capture/compare mode control block.
package ccmc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUNIT = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_ENH_CTRL = 8'h00;
  localparam logic [7:0] ADR_SEC_CTRL = 8'h04;
  localparam logic [7:0] ADR_ENH_VAL = 8'h08;
  localparam logic [7:0] ADR_SEC_VAL = 8'h0c;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SEC_CTRL_MASK = 8'h3f;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [1:0] FLAG_RST = 2'h0;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWI = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] GRP_CAPTURE = 2'h1;
  localparam logic [1:0] GRP_COMPARE = 2'h2;
  localparam logic [1:0] GRP_PWM = 2'h3;

  // ----------------------------------------------------------------
  // Output configuration codes and prescaler terminal counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;
  localparam logic [1:0] PRE4_MASK_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] mode_select_field;
  } ccmc_ctrl_t;

  typedef struct packed {
    logic [9:0] base;
    logic period;
  } ccmc_pwm_base_t;

endpackage : ccmc_pkg

// [verilog/ccmc_top.sv]
// Capture/compare mode control for two event units with a Wishbone slave.
//
// Operation
// - Mode 0000 turns the unit off and returns its state to reset.
// - Codes 0100..0111 capture on falling, rising, 4th or 16th rising edge.
// - Mode 1000 sets, 1001 clears the compare output on match; flag set.
// - First unit 0010 toggles output on match; second unit 0001..0011 reserved.
// - Mode 1010 only sets the flag on match; pin untouched.
// - Mode 1011 sets flag, resets timer, starts conversion if enabled.
// - First unit 11xx is pulse-width with A/C and B/D polarity; second unit 11xx is pulse-width on its one pin without polarity.
// - Outside pulse-width mode A is the unit pin; B, C, D are port pins.
// - Output configuration: single, full forward, half bridge, full reverse.
// - Control bits 5:4 are the low two bits of the 10-bit duty value.
// - A capture event copies the 16-bit timer into the capture pair.
// - Each capture sets the flag; only software clears it.
// - A newer capture overwrites the stored value with no overrun flag.
// - Pin should be input; a port-driven level change still counts as an event.
// - Prescaler clears when off, outside capture mode or on reset.
// - Special trigger asserts at match; timer reset at next timer clock edge.
// - Clearing the control register forces the compare latch low.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
module ccmc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer one and converter
  input wire logic [15:0] timer_one_count_i,
  output logic timer_reset_o,
  input wire logic adc_enable_i,
  output logic adc_start_o,
  // Pulse-width time base
  input wire ccmc_pkg::ccmc_pwm_base_t pwm_base_i,
  // First unit pins, vector order is {d, c, b, a}
  input wire logic output_a_i,
  output logic [3:0] enh_out_o,
  output logic [3:0] enh_oe_o,
  // Second unit pin
  input wire logic unit_pin_i,
  output logic unit_pin_o,
  output logic unit_pin_oe_o,
  // Interrupt
  output logic irq_o
);
  import ccmc_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Each register is one 32-bit word with its contents in the low bits.
  // The second control word reads bits 7:6 as zero, the status word is
  // read only and the clear word is write only, where a one clears a flag.
  // Unmapped addresses are acknowledged, read as zero and ignore writes.
  // Every access has one wait state: the request is registered on the
  // first edge and answered on the next, so ack never stands two cycles.
  logic ack_reg;
  logic [31:0] dat_reg;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rdata;

  ccmc_ctrl_t ctrl_reg [NUNIT];
  logic [15:0] val_reg [NUNIT];
  logic [1:0] flag_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] val_wr [NUNIT];
  logic [1:0] special;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // A write lands on the same edge at which the master sees ack.
  assign bus_wr = bus_req & wb_we_i & ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_ENH_CTRL: rdata[7:0] = ctrl_reg[0];
      ADR_SEC_CTRL: rdata[7:0] = ctrl_reg[1] & SEC_CTRL_MASK;
      ADR_ENH_VAL: rdata[15:0] = val_reg[0];
      ADR_SEC_VAL: rdata[15:0] = val_reg[1];
      ADR_IRQ_STAT: rdata[1:0] = flag_reg;
      ADR_IRQ_EN: rdata[1:0] = irq_en_reg;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Read data is taken when the request is first seen and held through
  // the acknowledge cycle, so the master samples a settled word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req & ~ack_reg) begin
      dat_reg <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Control, enable and clear writes use byte lane 0 only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg[0] <= CTRL_RST;
      ctrl_reg[1] <= CTRL_RST;
    end else if (bus_wr & wb_sel_i[0]) begin
      if (wb_adr_i == ADR_ENH_CTRL) begin
        ctrl_reg[0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ADR_SEC_CTRL) begin
        ctrl_reg[1] <= wb_dat_i[7:0] & SEC_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= FLAG_RST;
    end else if (bus_wr & wb_sel_i[0] & (wb_adr_i == ADR_IRQ_EN)) begin
      irq_en_reg <= wb_dat_i[1:0];
    end
  end

  assign val_wr[0] = (bus_wr & (wb_adr_i == ADR_ENH_VAL)) ? wb_sel_i[1:0] : 2'h0;
  assign val_wr[1] = (bus_wr & (wb_adr_i == ADR_SEC_VAL)) ? wb_sel_i[1:0] : 2'h0;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // The set term wins over a clear in the same cycle so no event is lost.
  assign flag_clr = (bus_wr & wb_sel_i[0] & (wb_adr_i == ADR_IRQ_CLR)) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= FLAG_RST;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  // The interrupt is a level so that a flag left set keeps asking.
  assign irq_o = |(flag_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Timer reset and conversion start
  // ----------------------------------------------------------------
  // The external timer acts on this at its next own clock edge.
  // A trigger from either unit resets the shared timer.
  assign timer_reset_o = |special;
  assign adc_start_o = timer_reset_o & adc_enable_i;

  // ----------------------------------------------------------------
  // Per-unit event logic
  // ----------------------------------------------------------------
  logic [3:0] out_reg [NUNIT];
  logic [3:0] oe_reg [NUNIT];

  generate
    for (genvar u = 0; u < NUNIT; u++) begin : g_unit
      logic pin_raw;
      logic sync1_reg;
      logic sync2_reg;
      logic sync3_reg;
      logic rise;
      logic fall;
      logic [3:0] mode;
      logic is_off;
      logic is_cap;
      logic is_pwm;
      logic is_drive;
      logic is_cmp;
      logic [3:0] pre_reg;
      logic cap_evt;
      logic match;
      logic match_q_reg;
      logic match_evt;
      logic latch_reg;
      logic [9:0] duty_reg;
      logic level_reg;
      logic [9:0] duty_new;
      logic [3:0] act;
      logic [3:0] pol;
      logic [3:0] out_next;
      logic [3:0] oe_next;

      assign pin_raw = (u == 0) ? output_a_i : unit_pin_i;
      assign mode = ctrl_reg[u].mode_select_field;
      assign is_off = (mode == MODE_OFF);
      assign is_cap = (mode[3:2] == GRP_CAPTURE);
      assign is_pwm = (mode[3:2] == GRP_PWM);
      assign is_drive = (mode == MODE_SET) | (mode == MODE_CLEAR) |
                        ((u == 0) & (mode == MODE_TOGGLE));
      assign is_cmp = (mode[3:2] == GRP_COMPARE) | ((u == 0) & (mode == MODE_TOGGLE));

      // The pad level is sampled whoever drives it, so a port write that
      // moves an output-configured pin is seen as an edge here.
      // The synchroniser runs in every mode so that turning a unit on with
      // the pin already high cannot show a false first edge.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          sync3_reg <= 1'b0;
        end else begin
          sync1_reg <= pin_raw;
          sync2_reg <= sync1_reg;
          sync3_reg <= sync2_reg;
        end
      end

      assign rise = sync2_reg & ~sync3_reg;
      assign fall = ~sync2_reg & sync3_reg;

      // Switching between prescale codes keeps the count, which can give
      // one early capture; software turns the unit off first to avoid it.
      always_ff @(posedge clk_i) begin
        if (rst_i | ~is_cap) begin
          pre_reg <= 4'h0;
        end else if (rise & ((mode == MODE_CAP_4) | (mode == MODE_CAP_16))) begin
          pre_reg <= pre_reg + 4'h1;
        end
      end

      assign cap_evt = ((mode == MODE_CAP_FALL) & fall) |
                       ((mode == MODE_CAP_RISE) & rise) |
                       ((mode == MODE_CAP_4) & rise & (pre_reg[1:0] == PRE4_MASK_LAST)) |
                       ((mode == MODE_CAP_16) & rise & (pre_reg == PRE16_LAST));

      // Only the first cycle of a match is an event; a timer that rests on
      // the compare value must not raise the flag again every cycle.
      assign match = (timer_one_count_i == val_reg[u]);
      assign match_evt = is_cmp & match & ~match_q_reg;
      assign special[u] = (mode == MODE_SPECIAL) & match;

      always_ff @(posedge clk_i) begin
        if (rst_i | ~is_cmp) begin
          match_q_reg <= 1'b0;
        end else begin
          match_q_reg <= match;
        end
      end

      // All compare actions and every capture raise the unit flag.
      assign flag_set[u] = cap_evt | match_evt;

      // Capture has priority over a bus write in the same cycle.
      // The high byte is read only while the unit runs pulse-width mode.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          val_reg[u] <= VAL_RST;
        end else if (cap_evt) begin
          val_reg[u] <= timer_one_count_i;
        end else begin
          if (val_wr[u][0]) begin
            val_reg[u][7:0] <= wb_dat_i[7:0];
          end
          if (val_wr[u][1] & ~is_pwm) begin
            val_reg[u][15:8] <= wb_dat_i[15:8];
          end
        end
      end

      // The compare latch is separate from any port data latch and idles low.
      always_ff @(posedge clk_i) begin
        if (rst_i | (ctrl_reg[u] == CTRL_RST) | is_off) begin
          latch_reg <= 1'b0;
        end else if (match_evt) begin
          if (mode == MODE_SET) begin
            latch_reg <= 1'b1;
          end else if (mode == MODE_CLEAR) begin
            latch_reg <= 1'b0;
          end else if (mode == MODE_TOGGLE) begin
            latch_reg <= ~latch_reg;
          end
        end
      end

      // Duty is double buffered: the new value only takes hold at a period
      // start, which keeps the output free of runt pulses.
      assign duty_new = {val_reg[u][7:0], ctrl_reg[u].duty_low_bits};

      always_ff @(posedge clk_i) begin
        if (rst_i | ~is_pwm) begin
          duty_reg <= 10'h000;
          level_reg <= 1'b0;
        end else if (pwm_base_i.period) begin
          duty_reg <= duty_new;
          level_reg <= (duty_new != 10'h000);
        end else if (pwm_base_i.base == duty_reg) begin
          level_reg <= 1'b0;
        end
      end

      // Half bridge drives B as the complement of A; dead-band delay is
      // left to the pad stage since no delay setting is held here.
      // Mode bit 1 inverts A and C, mode bit 0 inverts B and D.
      assign pol = {mode[0], mode[1], mode[0], mode[1]};

      always_comb begin
        act = 4'h0;
        oe_next = 4'h0;
        if (is_pwm & (u == 0)) begin
          unique case (ctrl_reg[u].output_config_field)
            CFG_SINGLE: begin
              act = {3'h0, level_reg};
              oe_next = 4'h1;
            end
            CFG_FULL_FWD: begin
              act = {level_reg, 2'h0, 1'b1};
              oe_next = 4'hf;
            end
            CFG_HALF: begin
              act = {2'h0, ~level_reg, level_reg};
              oe_next = 4'h3;
            end
            CFG_FULL_REV: begin
              act = {1'b0, 1'b1, level_reg, 1'b0};
              oe_next = 4'hf;
            end
          endcase
          out_next = (act ^ pol) & oe_next;
        end else if (is_pwm) begin
          out_next = {3'h0, level_reg};
          oe_next = 4'h1;
        end else begin
          // Only pin A belongs to the unit; modes 1010 and 1011 leave it free.
          out_next = {3'h0, latch_reg & is_drive};
          oe_next = {3'h0, is_drive};
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_reg[u] <= 4'h0;
          oe_reg[u] <= 4'h0;
        end else begin
          out_reg[u] <= out_next;
          oe_reg[u] <= oe_next;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Only bit 0 of the second unit's output set reaches a pin; its other
  // bits stay zero because that unit has a single pin.
  assign enh_out_o = out_reg[0];
  assign enh_oe_o = oe_reg[0];
  assign unit_pin_o = out_reg[1][0];
  assign unit_pin_oe_o = oe_reg[1][0];

endmodule : ccmc_top
